// *** pkg/rtc_pkg.sv ***
// Constants for the calendar clock counter: register map, field
// positions, reset values and the one-second divider count.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package rtc_pkg;

   // ************************************************************
   // Register byte addresses
   // ************************************************************
   localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SECONDS = 8'h04;
   localparam logic [7:0] ADDR_MINUTES = 8'h08;
   localparam logic [7:0] ADDR_HOURS = 8'h0c;
   localparam logic [7:0] ADDR_WEEKDAY = 8'h10;
   localparam logic [7:0] ADDR_DATE = 8'h14;
   localparam logic [7:0] ADDR_MONTH = 8'h18;
   localparam logic [7:0] ADDR_YEAR = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h20;
   localparam logic [7:0] ADDR_STANDBY = 8'h24;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int RUN_BIT = 7;
   localparam int STANDBY_BIT = 2;
   localparam int IRQ_LEVEL_W = 3;
   localparam int SECOND_EVT_BIT = 0;

   // ************************************************************
   // Reset values (calendar starts at Sat 2000-01-01 00:00:00)
   // ************************************************************
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic STANDBY_RESET = 1'b1;
   localparam logic [2:0] IRQ_LEVEL_RESET = 3'h0;
   localparam logic IRQ_MASK_RESET = 1'b0;
   localparam logic [5:0] SECONDS_RESET = 6'h00;
   localparam logic [5:0] MINUTES_RESET = 6'h00;
   localparam logic [4:0] HOURS_RESET = 5'h00;
   localparam logic [2:0] WEEKDAY_RESET = 3'h6;
   localparam logic [4:0] DATE_RESET = 5'h01;
   localparam logic [3:0] MONTH_RESET = 4'h1;
   localparam logic [6:0] YEAR_RESET = 7'h00;

   // ************************************************************
   // Calendar limits and timing
   // ************************************************************
   localparam logic [5:0] SEC_MAX = 6'h3b;
   localparam logic [5:0] MIN_MAX = 6'h3b;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [2:0] WEEKDAY_MAX = 3'h6;
   localparam logic [3:0] MONTH_MAX = 4'hc;
   localparam logic [6:0] YEAR_MAX = 7'h63;
   localparam int YEAR_BASE = 2000;
   localparam int SYS_CLK_HZ = 100000000;
   localparam int SUB_CLK_HZ = 32768;
   // Cycles of i_mclk per one-second tick
   localparam int SECOND_CYCLES = SYS_CLK_HZ;
   localparam int SUB_TICKS_PER_SEC = SUB_CLK_HZ;
endpackage

// *** hw/calendar_rtc_counter.sv ***
// Calendar real-time clock counter with APB register access.
// Binary registers only; no 12-hour mode and no alarm.
// Limitation: the prescaler can be neither read nor preset.
// Assumes one 100 MHz clock; the 32.768 kHz count source is a pin
// and is synchronised before use. Software loads and starts it.
//
// Contract
// [R1] Hours run 0..23 then wrap to 0 and advance the date.
// [R2] One second after 2099-12-31 23:59:59 comes 2000-01-01 00:00:00.
// [R3] A once-per-second interrupt request is raised while counting.
// [R4] One second is exactly 32768 edges of the sub-clock source.
// [R5] Control bit 7 is the run bit, readable and writable.
// [R6] Seconds, minutes, hours, weekday, date, month, year each readable.
// [R7] Software loads a start time; counting continues from it.
// [R8] Software sets up clocks before setting the run bit.
// [R9] An interrupt level of zero disables the clock interrupt.
// [R10] Block counts only while standby bit 2 is zero.
// [R11] Date wraps by month length; February has 29 days in leap years.
// [R12] Weekday advances cyclically through seven values at each day wrap.
`timescale 1ns/100ps
module calendar_rtc_counter (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_sub_clock_source,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq
);

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] clock_control;
   logic clock_standby;
   logic [2:0] irq_level;
   logic irq_status;
   logic irq_mask;
   logic [5:0] seconds_value;
   logic [5:0] minutes_value;
   logic [4:0] hours_value;
   logic [2:0] weekday_value;
   logic [4:0] date_value;
   logic [3:0] month_value;
   logic [6:0] year_value;
   logic [14:0] sub_count;
   logic sync_a;
   logic sync_b;
   logic sync_c;
   logic [31:0] prdata;

   // Next values, all from one combinational process
   logic [7:0] next_clock_control;
   logic next_clock_standby;
   logic [2:0] next_irq_level;
   logic next_irq_status;
   logic next_irq_mask;
   logic [5:0] next_seconds_value;
   logic [5:0] next_minutes_value;
   logic [4:0] next_hours_value;
   logic [2:0] next_weekday_value;
   logic [4:0] next_date_value;
   logic [3:0] next_month_value;
   logic [6:0] next_year_value;
   logic [14:0] next_sub_count;
   logic [31:0] next_prdata;

   // Bus strobes and calendar enables
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic running;
   logic sub_edge;
   logic second_tick;
   logic [4:0] month_len;

   // ************************************************************
   // Sub-clock synchroniser and edge detection
   // ************************************************************
   // Third stage only feeds the edge detector, keeping stage one clean
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= i_sub_clock_source;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   assign sub_edge = sync_b & ~sync_c;
   // Counting needs run set and standby clear
   assign running = clock_control[rtc_pkg::RUN_BIT] &
                    ~clock_standby; // [R5] [R10]
   // The last edge of a full prescaler turn makes one second
   assign second_tick = running & sub_edge &
      (sub_count == 15'(rtc_pkg::SUB_TICKS_PER_SEC - 1)); // [R4]

   // ************************************************************
   // APB decode
   // ************************************************************
   // Zero wait states: the slave is always ready
   assign o_pready = 1'b1;
   // Writes land in the access phase; reads sample in setup
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign rd_en = i_psel & ~i_penable & ~i_pwrite;
   // Unaligned or unmapped places answer with an error
   assign addr_ok = (i_paddr[1:0] == 2'h0) &&
                    (i_paddr <= rtc_pkg::ADDR_IRQ_MASK);
   assign o_pslverr = i_psel & i_penable & ~addr_ok;
   assign o_prdata = prdata;
   // Level output from status gated by mask and a nonzero level
   assign o_irq = irq_status & irq_mask & (|irq_level); // [R9]

   // ************************************************************
   // Month length
   // ************************************************************
   // Every year divisible by four in 2000..2099 is a leap year
   // Out-of-range months fall to the 31-day default
   always_comb begin
      case (month_value)
         4'h2: month_len = (year_value[1:0] == 2'h0) ? 5'h1d : 5'h1c; // [R11]
         4'h4, 4'h6, 4'h9, 4'hb: month_len = 5'h1e;
         default: month_len = 5'h1f;
      endcase
   end

   // ************************************************************
   // Next-state: registers and calendar
   // ************************************************************
   always_comb begin
      next_clock_control = clock_control;
      next_clock_standby = clock_standby;
      next_irq_level = irq_level;
      next_irq_status = irq_status;
      next_irq_mask = irq_mask;
      next_seconds_value = seconds_value;
      next_minutes_value = minutes_value;
      next_hours_value = hours_value;
      next_weekday_value = weekday_value;
      next_date_value = date_value;
      next_month_value = month_value;
      next_year_value = year_value;
      next_sub_count = sub_count;
      next_prdata = prdata;

      // Prescaler holds while stopped so a restart resumes the partial second
      if (running && sub_edge) begin
         next_sub_count = sub_count + 15'h0001; // [R4]
      end

      // Calendar carry chain
      if (second_tick) begin
         if (seconds_value >= rtc_pkg::SEC_MAX) begin
            next_seconds_value = 6'h00;
            if (minutes_value >= rtc_pkg::MIN_MAX) begin
               next_minutes_value = 6'h00;
               if (hours_value >= rtc_pkg::HOUR_MAX) begin
                  next_hours_value = 5'h00; // [R1]
                  if (weekday_value >= rtc_pkg::WEEKDAY_MAX) begin
                     next_weekday_value = 3'h0; // [R12]
                  end else begin
                     next_weekday_value = weekday_value + 3'h1; // [R12]
                  end
                  if (date_value >= month_len) begin
                     next_date_value = 5'h01; // [R11]
                     if (month_value >= rtc_pkg::MONTH_MAX) begin
                        next_month_value = 4'h1;
                        if (year_value >= rtc_pkg::YEAR_MAX) begin
                           next_year_value = 7'h00; // [R2]
                        end else begin
                           next_year_value = year_value + 7'h01;
                        end
                     end else begin
                        next_month_value = month_value + 4'h1;
                     end
                  end else begin
                     next_date_value = date_value + 5'h01; // [R1]
                  end
               end else begin
                  next_hours_value = hours_value + 5'h01; // [R1]
               end
            end else begin
               next_minutes_value = minutes_value + 6'h01;
            end
         end else begin
            next_seconds_value = seconds_value + 6'h01;
         end
      end

      // Software writes override the carry in the same cycle
      if (wr_en) begin
         if (i_paddr == rtc_pkg::ADDR_CLOCK_CONTROL) begin
            next_clock_control = i_pwdata[7:0]; // [R5]
         end else if (i_paddr == rtc_pkg::ADDR_SECONDS) begin
            next_seconds_value = i_pwdata[5:0]; // [R7]
            next_sub_count = 15'h0000;
         end else if (i_paddr == rtc_pkg::ADDR_MINUTES) begin
            next_minutes_value = i_pwdata[5:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_HOURS) begin
            next_hours_value = i_pwdata[4:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_WEEKDAY) begin
            next_weekday_value = i_pwdata[2:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_DATE) begin
            next_date_value = i_pwdata[4:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_MONTH) begin
            next_month_value = i_pwdata[3:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_YEAR) begin
            next_year_value = i_pwdata[6:0]; // [R7]
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_CONTROL) begin
            next_irq_level = i_pwdata[2:0]; // [R9]
         end else if (i_paddr == rtc_pkg::ADDR_STANDBY) begin
            next_clock_standby = i_pwdata[rtc_pkg::STANDBY_BIT]; // [R10]
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_STATUS) begin
            if (i_pwdata[rtc_pkg::SECOND_EVT_BIT]) begin
               next_irq_status = 1'b0;
            end
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = i_pwdata[rtc_pkg::SECOND_EVT_BIT];
         end
      end

      // Set after clear: a tick in the clearing cycle is kept
      if (second_tick) begin
         next_irq_status = 1'b1; // [R3]
      end

      // Read data captured in the setup cycle
      if (rd_en) begin
         next_prdata = 32'h0000_0000;
         if (i_paddr == rtc_pkg::ADDR_CLOCK_CONTROL) begin
            next_prdata[7:0] = clock_control; // [R5]
         end else if (i_paddr == rtc_pkg::ADDR_SECONDS) begin
            next_prdata[5:0] = seconds_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_MINUTES) begin
            next_prdata[5:0] = minutes_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_HOURS) begin
            next_prdata[4:0] = hours_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_WEEKDAY) begin
            next_prdata[2:0] = weekday_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_DATE) begin
            next_prdata[4:0] = date_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_MONTH) begin
            next_prdata[3:0] = month_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_YEAR) begin
            next_prdata[6:0] = year_value; // [R6]
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_CONTROL) begin
            next_prdata[2:0] = irq_level;
         end else if (i_paddr == rtc_pkg::ADDR_STANDBY) begin
            next_prdata[rtc_pkg::STANDBY_BIT] = clock_standby;
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_STATUS) begin
            next_prdata[rtc_pkg::SECOND_EVT_BIT] = irq_status;
         end else if (i_paddr == rtc_pkg::ADDR_IRQ_MASK) begin
            next_prdata[rtc_pkg::SECOND_EVT_BIT] = irq_mask;
         end
      end
   end

   // ************************************************************
   // State registers
   // ************************************************************
   // Synchronous reset; every state bit starts from a constant
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         clock_control <= rtc_pkg::CONTROL_RESET;
         clock_standby <= rtc_pkg::STANDBY_RESET;
         irq_level <= rtc_pkg::IRQ_LEVEL_RESET;
         irq_status <= 1'b0;
         irq_mask <= rtc_pkg::IRQ_MASK_RESET;
         seconds_value <= rtc_pkg::SECONDS_RESET;
         minutes_value <= rtc_pkg::MINUTES_RESET;
         hours_value <= rtc_pkg::HOURS_RESET;
         weekday_value <= rtc_pkg::WEEKDAY_RESET;
         date_value <= rtc_pkg::DATE_RESET;
         month_value <= rtc_pkg::MONTH_RESET;
         year_value <= rtc_pkg::YEAR_RESET;
         sub_count <= 15'h0000;
         prdata <= 32'h0000_0000;
      end else begin
         clock_control <= next_clock_control;
         clock_standby <= next_clock_standby;
         irq_level <= next_irq_level;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         seconds_value <= next_seconds_value;
         minutes_value <= next_minutes_value;
         hours_value <= next_hours_value;
         weekday_value <= next_weekday_value;
         date_value <= next_date_value;
         month_value <= next_month_value;
         year_value <= next_year_value;
         sub_count <= next_sub_count;
         prdata <= next_prdata;
      end
   end
endmodule

// *** verification/rtc_checker_asserts.sv ***
// Port relations of the calendar clock counter: bus answers, read data
// and the interrupt line. Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
module rtc_checker (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_irq
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   logic acc;
   logic bad;
   logic rd_setup;
   logic ctl_wr;
   // Access phase, bad address and read setup as the bus shows them
   assign acc = i_psel && i_penable;
   assign bad = (i_paddr[1:0] != 2'h0) || (i_paddr > rtc_pkg::ADDR_IRQ_MASK);
   assign rd_setup = i_psel && !i_penable && !i_pwrite;
   assign ctl_wr = acc && i_pwrite && (i_pwdata[0] == 1'b0);
   // ********************************
   // Bus answers
   // ********************************
   a_pready_high: assert property (o_pready)
      else $error("pready low");
   a_slverr_bad: assert property (acc && bad |-> o_pslverr)
      else $error("bad address not refused");
   a_slverr_good: assert property (acc && !bad |-> !o_pslverr)
      else $error("good address refused");
   a_slverr_idle: assert property (!acc |-> !o_pslverr)
      else $error("error outside access phase");
   a_bad_read_zero: assert property (rd_setup && bad ##1 acc
      |-> o_prdata == 32'h0)
      else $error("bad address read not zero");
   a_upper_zero: assert property (rd_setup && !bad ##1 acc
      |-> o_prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_prdata_hold: assert property (!rd_setup |=> $stable(o_prdata))
      else $error("read data moved without a read");
   // ********************************
   // Interrupt line
   // ********************************
   a_irq_after_rst: assert property ($fell(i_sys_rst) |-> !o_irq)
      else $error("interrupt high after reset");
   a_level_zero_off: assert property (ctl_wr && i_pwdata[2:0] == 3'h0
      && i_paddr == rtc_pkg::ADDR_IRQ_CONTROL |=> !o_irq [*2])
      else $error("interrupt with level zero");
   a_mask_off: assert property (ctl_wr
      && i_paddr == rtc_pkg::ADDR_IRQ_MASK |=> !o_irq)
      else $error("interrupt while masked");
   // Main scenarios reached
   c_bad: cover property (acc && bad);
   c_irq: cover property ($rose(o_irq));
   c_sec: cover property (acc && i_paddr == rtc_pkg::ADDR_SECONDS);
endmodule

bind calendar_rtc_counter rtc_checker rtc_checker_inst (.i_mclk(i_mclk),
   .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_irq(o_irq));

// *** verification/tb.sv ***
// Self-checking bench of the calendar clock counter over APB.
// Assumes the counter package; drives the sub-clock pin itself.
`timescale 1ns/100ps
module tb;
   localparam logic [7:0] SEC = rtc_pkg::ADDR_SECONDS;
   localparam logic [7:0] CTL = rtc_pkg::ADDR_CLOCK_CONTROL;
   localparam logic [7:0] STS = rtc_pkg::ADDR_IRQ_STATUS;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic sub_src = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [6:0] et [7];
   logic [15:0] lfsr_q = 16'haacb;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   calendar_rtc_counter calendar_rtc_counter_inst (.i_mclk(mclk),
      .i_sys_rst(sys_rst), .i_sub_clock_source(sub_src), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_irq(irq));
   always #5 mclk = ~mclk;
   // Hang guard: four full seconds of sub-clock edges cost most of it
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 800000) begin
         n_fail++;
         end_sim();
      end
   end
   // ********************************
   // Expectation helpers
   // ********************************
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0],
         lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction
   // Year field is 2000-based, so every multiple of four is a leap year
   function automatic logic [6:0] mdays(input logic [6:0] m,
         input logic [6:0] y);
      case (m)
         7'h02: return (y[1:0] == 2'h0) ? 7'h1d : 7'h1c;
         7'h04, 7'h06, 7'h09, 7'h0b: return 7'h1e;
         default: return 7'h1f;
      endcase
   endfunction
   // One second onward in the expected calendar
   function automatic void advance();
      et[0] = et[0] + 7'h01;
      if (et[0] == 7'h3c) begin
         et[0] = 7'h00;
         et[1] = et[1] + 7'h01;
      end
      if (et[1] == 7'h3c) begin
         et[1] = 7'h00;
         et[2] = et[2] + 7'h01;
      end
      if (et[2] == 7'h18) begin
         et[2] = 7'h00;
         et[3] = (et[3] == 7'h06) ? 7'h00 : et[3] + 7'h01;
         et[4] = et[4] + 7'h01;
      end
      if (et[4] > mdays(et[5], et[6])) begin
         et[4] = 7'h01;
         et[5] = et[5] + 7'h01;
      end
      if (et[5] == 7'h0d) begin
         et[5] = 7'h01;
         et[6] = (et[6] == 7'h63) ? 7'h00 : et[6] + 7'h01;
      end
   endfunction
   // ********************************
   // Bus and pin tasks
   // ********************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer; an idle edge after it keeps drivers from clashing
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
   endtask
   // Source period of five clocks, safely slower than a quarter clock
   task automatic edges(input int n);
      repeat (n) begin
         sub_src <= 1'b1;
         repeat (2) @(posedge mclk);
         sub_src <= 1'b0;
         repeat (3) @(posedge mclk);
      end
   endtask
   task automatic rd_all();
      for (int i = 0; i < 7; i++) begin
         rd(SEC + 8'(4 * i), 32'(et[i]));
      end
   endtask
   // Seconds last, since that write also clears the prescaler
   task automatic load();
      for (int i = 6; i >= 0; i--) begin
         wr(SEC + 8'(4 * i), 32'(et[i]));
      end
   endtask
   // Only the last of the edges may move the calendar
   task automatic tick();
      wr(STS, 32'h1);
      edges(32767);
      rd(SEC, 32'(et[0]));
      rd(STS, 32'h0);
      edges(1);
      repeat (8) @(posedge mclk);
      advance();
      rd_all();
      rd(STS, 32'h1);
   endtask
   task automatic corner(input logic [6:0] y, m, d, w);
      et = '{7'h3b, 7'h3b, 7'h17, w, d, m, y};
      load();
      tick();
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ********************************
   // Main sequence
   // ********************************
   initial begin
      logic [31:0] q;
      logic e;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd(CTL, 32'h0);
      rd(rtc_pkg::ADDR_STANDBY, 32'h4);
      rd(rtc_pkg::ADDR_IRQ_CONTROL, 32'h0);
      et = '{7'h00, 7'h00, 7'h00, 7'h06, 7'h01, 7'h01, 7'h00};
      rd_all();
      // Unmapped and unaligned places are refused
      apb(1'b0, 8'h30, 32'h0, q, e);
      chk(q, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 8'h05, 32'hff, q, e);
      chk(32'(e), 32'h1);
      wr(CTL, 32'h80);
      rd(CTL, 32'h80);
      // Random start; edges while in standby or stopped are ignored
      et[0] = 7'(rnd() % 59);
      et[1] = 7'(rnd() % 60);
      et[2] = 7'(rnd() % 24);
      et[3] = 7'(rnd() % 7);
      et[4] = 7'(rnd() % 28 + 1);
      et[5] = 7'(rnd() % 12 + 1);
      et[6] = 7'(rnd() % 100);
      load();
      edges(50);
      wr(rtc_pkg::ADDR_STANDBY, 32'h0);
      wr(CTL, 32'h0);
      edges(50);
      wr(CTL, 32'h80);
      wr(rtc_pkg::ADDR_IRQ_MASK, 32'h1);
      wr(rtc_pkg::ADDR_IRQ_CONTROL, 32'h0);
      tick();
      chk(32'(irq), 32'h0);
      for (int l = 7; l >= 0; l--) begin
         wr(rtc_pkg::ADDR_IRQ_CONTROL, 32'(l));
         chk(32'(irq), 32'(l != 0));
      end
      wr(rtc_pkg::ADDR_IRQ_CONTROL, 32'(rnd() % 7 + 1));
      wr(rtc_pkg::ADDR_IRQ_MASK, 32'h0);
      chk(32'(irq), 32'h0);
      wr(rtc_pkg::ADDR_IRQ_MASK, 32'h1);
      wr(STS, 32'h1);
      chk(32'(irq), 32'h0);
      // Year end, leap February 28 to 29, and plain February end
      corner(7'h63, 7'h0c, 7'h1f, 7'h06);
      corner(7'h18, 7'h02, 7'h1c, 7'h03);
      corner(7'h17, 7'h02, 7'h1c, 7'h02);
      end_sim();
   end
endmodule
